// ### design/pcof_core.sv
// cycle length select and sticky pwm overflow flag
// assumes counter and channel modes come from the surrounding pwm unit, same clock
// Summary of operation
// [R1] flag sets when main counter carries out of bit 7..10
// [R2] select field picks which counter bit drives the flag
// [R3] hardware or firmware sets flag; only firmware write clears it
// [R4] flag reads 0 with no overflow since clear, else 1
// [R5] software writes zero into the reserved field
// [R6] without 16-bit mode, select sets the pwm cycle length
// [R7] one select setting applies to all variable-length channels
// [R8] 16-bit channels ignore select and run full width
`include "pcof_params.svh"
`default_nettype none
module pcof_core
	import pcof_pkg::*;
#(
	parameter int CNT_W = `PCOF_CNT_W,
	parameter int CHANNELS = `PCOF_CHANNELS
) (
	input wire logic core_clk, // clock
	input wire logic reset_n, // async reset, active low
	input wire logic [CNT_W-1:0] main_array_counter, // main counter value
	input wire logic [CHANNELS-1:0] chan_mode16, // channel in 16-bit pwm mode
	input wire pcof_ctrl_wr_t ctrl_wr, // firmware control write
	output logic overflow_flag, // sticky overflow flag
	output pcof_len_t pwm_cycle_length_select, // current select field
	output logic [`PCOF_RSVD_W-1:0] rsvd_rd, // reserved field readback
	output logic [CHANNELS-1:0][CNT_W-1:0] chan_cycle_max, // per-channel top count
	output logic [CHANNELS-1:0] chan_wrap // per-channel cycle end pulse
);
	// the full-width wrap must sit above the widest selectable cycle
	generate
		if (CNT_W <= `PCOF_MAX_BITS) begin : g_bad_cnt_w
			$error("pcof_core: CNT_W must exceed the widest selectable cycle");
		end
		if (CHANNELS < 1) begin : g_bad_channels
			$error("pcof_core: CHANNELS must be at least 1");
		end
	endgenerate

	// reset synchroniser
	logic rst_s1_r;
	logic rst_n_r;
	// control field copies
	logic flag_r;
	logic flag_nxt;
	pcof_len_t len_r;
	pcof_len_t len_nxt;
	logic [`PCOF_RSVD_W-1:0] rsvd_r;
	logic [`PCOF_RSVD_W-1:0] rsvd_nxt;
	// counter history for edge detection
	logic [CNT_W-1:0] cnt_prev_r;
	// decoded events
	logic wrap_sel;
	logic wrap_full;
	logic [CNT_W-1:0] var_max;
	// per-channel results
	logic [CHANNELS-1:0][CNT_W-1:0] max_r;
	logic [CHANNELS-1:0] wrap_r;

	// top bit index of the cycle for a select code
	function automatic int unsigned len_top(input pcof_len_t l);
		return `PCOF_MIN_BITS - 1 + int'(l);
	endfunction

	// carry out of bit k: it was set and now is clear
	function automatic logic fell(input logic [CNT_W-1:0] prev, input logic [CNT_W-1:0] cur,
		input int unsigned k);
		return prev[k] & ~cur[k];
	endfunction

	// all ones up to and including the top bit of the selected cycle
	function automatic logic [CNT_W-1:0] cycle_top(input pcof_len_t l);
		logic [CNT_W-1:0] top;
		top = '0;
		for (int i = 0; i < CNT_W; i++) begin
			top[i] = (i <= int'(len_top(l)));
		end
		return top;
	endfunction

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r)
			cnt_prev_r <= '0;
		else
			cnt_prev_r <= main_array_counter;
	end

	// wrap uses the stored select, so a new select applies from the next cycle on
	always_comb begin
		wrap_sel = fell(cnt_prev_r, main_array_counter, len_top(len_r)); // [R1] [R2]
		wrap_full = fell(cnt_prev_r, main_array_counter, CNT_W - 1); // [R8]
		var_max = cycle_top(len_r); // [R6]
	end

	always_comb begin
		len_nxt = len_r;
		rsvd_nxt = rsvd_r;
		if (ctrl_wr.wr) begin
			len_nxt = ctrl_wr.len_wdata;
			// stored as written; firmware keeps it zero
			rsvd_nxt = ctrl_wr.rsvd_wdata; // [R5]
		end
	end

	// hardware set wins over a firmware clear in the same cycle, so no wrap is lost
	always_comb begin
		flag_nxt = flag_r;
		if (wrap_sel) begin
			flag_nxt = 1'b1; // [R3] [R4]
		end else if (ctrl_wr.wr) begin
			flag_nxt = ctrl_wr.flag_wdata; // [R3]
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			len_r <= pcof_len_t'(`PCOF_LEN_SEL_RST);
		end else begin
			len_r <= len_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rsvd_r <= `PCOF_RSVD_RST;
		end else begin
			rsvd_r <= rsvd_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
			always_ff @(posedge core_clk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					max_r[c] <= '0;
				end else if (chan_mode16[c]) begin
					max_r[c] <= '1; // [R8]
				end else begin
					max_r[c] <= var_max; // [R6] [R7]
				end
			end

			always_ff @(posedge core_clk or negedge rst_n_r) begin
				if (!rst_n_r) begin
					wrap_r[c] <= 1'b0;
				end else if (chan_mode16[c]) begin
					wrap_r[c] <= wrap_full; // [R8]
				end else begin
					wrap_r[c] <= wrap_sel; // [R7]
				end
			end
		end
	endgenerate

	assign overflow_flag = flag_r;
	assign pwm_cycle_length_select = len_r;
	assign rsvd_rd = rsvd_r;
	assign chan_cycle_max = max_r;
	assign chan_wrap = wrap_r;
endmodule
`default_nettype wire

// ### design/pcof_params.svh
// constants for the pwm cycle length and overflow flag block
// assumes inclusion by bare name from design files only
`ifndef PCOF_PARAMS_SVH
`define PCOF_PARAMS_SVH
`define PCOF_LEN_SEL_W 2
`define PCOF_LEN_SEL_RST 2'h0
`define PCOF_RSVD_W 3
`define PCOF_RSVD_RST 3'h0
`define PCOF_MIN_BITS 8
`define PCOF_MAX_BITS 11
`define PCOF_CNT_W 16
`define PCOF_CHANNELS 6
`endif

// ### design/pcof_pkg.sv
// types for the pwm cycle length and overflow flag block
// assumes pcof_params.svh is on the include path
`include "pcof_params.svh"
`default_nettype none
package pcof_pkg;
	typedef enum logic [1:0] {
		PCOF_LEN_8 = 2'h0,
		PCOF_LEN_9 = 2'h1,
		PCOF_LEN_10 = 2'h2,
		PCOF_LEN_11 = 2'h3
	} pcof_len_t;
	typedef struct packed {
		logic wr;
		logic flag_wdata;
		pcof_len_t len_wdata;
		logic [`PCOF_RSVD_W-1:0] rsvd_wdata;
	} pcof_ctrl_wr_t;
endpackage
`default_nettype wire

// ### tb/pcof_core_checker.sv
// checker for pcof_core flag, select and wrap ports
// assumes bind into pcof_core, single clock, counter sampled each edge
`default_nettype none
module pcof_core_checker import pcof_pkg::*; #(parameter int CNT_W = 16, parameter int CHANNELS = 6) (
	input wire logic core_clk, // clk
	input wire logic reset_n, // rst
	input wire logic [CNT_W-1:0] main_array_counter, // count
	input wire logic [CHANNELS-1:0] chan_mode16, // modes
	input wire pcof_ctrl_wr_t ctrl_wr, // write
	input wire logic overflow_flag, // flag
	input wire pcof_len_t pwm_cycle_length_select, // select
	input wire logic [CHANNELS-1:0] chan_wrap // wraps
);
	logic [1:0] up_r;
	logic [CNT_W-1:0] pv_r;
	// design holds its synced reset two edges longer, so wait it out
	always_ff @(posedge core_clk or negedge reset_n) if (!reset_n) up_r <= '0; else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	always_ff @(posedge core_clk) pv_r <= main_array_counter;
	wire ok = &up_r;
	wire wp = pv_r[7 + pwm_cycle_length_select] & ~main_array_counter[7 + pwm_cycle_length_select];
	wire cl = ctrl_wr.wr & ~ctrl_wr.flag_wdata;
	wire st = ctrl_wr.wr & ctrl_wr.flag_wdata;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_set; ok && wp |=> overflow_flag; endproperty
	a_set: assert property (p_set) else $error("flag not set on wrap");
	property p_stk; ok && overflow_flag && !cl |=> overflow_flag; endproperty
	a_stk: assert property (p_stk) else $error("flag dropped");
	property p_clr; ok && cl && !wp |=> !overflow_flag; endproperty
	a_clr: assert property (p_clr) else $error("flag not cleared");
	property p_fws; ok && st |=> overflow_flag; endproperty
	a_fws: assert property (p_fws) else $error("flag not set by write");
	property p_sel; ok && ctrl_wr.wr |=> pwm_cycle_length_select == $past(ctrl_wr.len_wdata); endproperty
	a_sel: assert property (p_sel) else $error("select not taken");
	property p_wrp; ok && wp |=> &(chan_wrap | $past(chan_mode16)); endproperty
	a_wrp: assert property (p_wrp) else $error("channel missed wrap");
	property p_w16; ok && chan_mode16[0] && pv_r[CNT_W-1] && !main_array_counter[CNT_W-1] |=> chan_wrap[0]; endproperty
	a_w16: assert property (p_w16) else $error("full width wrap missed");
	c_wrp: cover property (ok && wp && cl);
	c_w16: cover property (ok && chan_mode16[0] && chan_wrap[0]);
	c_fws: cover property (ok && st && !overflow_flag);
endmodule
bind pcof_core pcof_core_checker #(.CNT_W(CNT_W), .CHANNELS(CHANNELS)) i_chk (.*);
`default_nettype wire

// ### tb/pcof_core_tb_top.sv
// random bench for pcof_core flag and select
// assumes pcof_pkg, pcof_core and the checker are compiled first
`default_nettype none
module pcof_core_tb_top import pcof_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 0, reset_n = 0, fl = 0, w, of;
	logic [15:0] cnt = 0, pc;
	logic [5:0] m16 = 0;
	logic [5:0] cwo;
	logic [5:0][15:0] mx;
	logic [2:0] rr;
	pcof_ctrl_wr_t cw = '0;
	pcof_len_t se = PCOF_LEN_8, so;
	int mismatches = 0, cmp_count = 0;
	pcof_core i_dut (.core_clk, .reset_n, .main_array_counter(cnt), .chan_mode16(m16), .ctrl_wr(cw),
		.overflow_flag(of), .pwm_cycle_length_select(so), .rsvd_rd(rr), .chan_cycle_max(mx), .chan_wrap(cwo));
	always #2 core_clk = ~core_clk;
	// top count: full width in 16-bit mode, else 8..11 low bits set
	function automatic logic [15:0] exp_max(input logic m, input pcof_len_t l);
		if (m) return 16'hffff;
		return 16'((32'h0000_0001 << (8 + int'(l))) - 32'h0000_0001);
	endfunction
	task chk(string n, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (e !== s) begin
			mismatches++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task print_verdict;
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#40000;
		mismatches++;
		print_verdict;
	end
	initial begin
		void'($urandom(61240));
		repeat (2) @(negedge core_clk);
		reset_n = 1;
		repeat (3) @(negedge core_clk);
		chk("flag", 16'h0000, 16'(of));
		// small steps make every selected bit fall often; clears collide with wraps now and then
		repeat (3000) begin
			pc = cnt;
			cnt = cnt + 16'($urandom_range(40, 1));
			cw = '0;
			if ($urandom_range(7) == 0) cw = {1'b1, 1'($urandom), 2'($urandom), 3'h0};
			if ($urandom_range(31) == 0) m16 = 6'($urandom);
			@(negedge core_clk);
			w = pc[7 + se] & ~cnt[7 + se];
			fl = w | (cw.wr ? cw.flag_wdata : fl);
			// per-channel results use the select that stood at the edge
			for (int c = 0; c < 6; c++) begin
				chk("wrap", 16'(m16[c] ? pc[15] & ~cnt[15] : w), 16'(cwo[c]));
				chk("max", exp_max(m16[c], se), mx[c]);
			end
			if (cw.wr) se = cw.len_wdata;
			chk("flag", 16'(fl), 16'(of));
			chk("select", 16'(se), 16'(so));
			chk("rsvd", 16'h0000, 16'(rr));
		end
		print_verdict;
	end
endmodule
`default_nettype wire
